// >>> hdl/general_event_legacy_pkg.sv
/*
 * shared constants and request carriers for the general event register and the
 * legacy card register access paths.
 * assumes a single 25 MHz system clock and a host that issues single requests.
 */
`default_nettype none
package general_event_legacy_pkg;
	// configuration dword offsets
	localparam logic [7:0] CFG_SOCK_BASE = 8'h10; // socket window base, per function
	localparam logic [7:0] CFG_LEGACY_BASE = 8'h44; // legacy i/o base, shared
	localparam logic [7:0] CFG_ROUTE = 8'h8C; // multifunction routing
	localparam logic [7:0] CFG_EVENT = 8'hA8; // general event control/status
	// routing field for multifunction_terminal_five
	localparam int ROUTE_LSB = 20;
	localparam logic [2:0] ROUTE_EVENT_CODE = 3'h5;
	// event register layout
	localparam int STS_LSB = 8; // status bits 10..8
	localparam int STS_BE = 1; // byte lane holding the status bits
	localparam int EN_BE = 0; // byte lane holding the enable bits
	localparam int ROUTE_BE = 2; // byte lane holding the routing field
	localparam logic [15:0] EVENT_RESET = 16'h0001;
	// socket window layout
	localparam int WIN_LSB = 12; // 4K window
	localparam logic [11:0] ALIAS_LO = 12'h800; // first alias byte
	localparam logic [11:0] ALIAS_HI = 12'h844; // last alias byte
	localparam logic [11:0] ALIAS_REG_END = 12'h840; // this byte and those above map to no register
	localparam int SOCK_SEL_BIT = 6; // index bit selecting socket b
	localparam int IDX_OOR_BIT = 7; // index bit above the 128 registers

	// configuration request
	typedef struct packed {
		logic valid;
		logic write;
		logic func; // function 0 or 1
		logic [7:0] offset; // dword aligned byte offset
		logic [3:0] be; // byte enables
		logic [31:0] wdata;
	} cfg_req_t;

	// host i/o request, byte wide
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} io_req_t;

	// host memory request, byte wide
	typedef struct packed {
		logic valid;
		logic write;
		logic func; // function whose window is addressed
		logic [31:0] addr;
		logic [7:0] wdata;
	} mem_req_t;
endpackage
`default_nettype wire

// >>> hdl/general_event_legacy_regs.sv
/*
 * general event control/status register plus index/data and memory alias
 * access to the 128 legacy card registers of both sockets.
 * assumes requests are synchronous to i_sys_clk, one per port per cycle, and
 * that the socket logic presents the video enable and 12 v request levels.
 */
// What this block does
// R1 - event output only when routing selects it
// R2 - bits 15..11 read as zero
// R3 - socket 1 video change sets bit 10
// R4 - socket 0 video change sets bit 9
// R5 - 12 v request change sets bit 8
// R6 - bits 7..3 read as zero
// R7 - enable bit 2 gates socket 1 event
// R8 - enable bit 1 gates socket 0 event
// R9 - enable bit 0 gates voltage event
// R10 - index port selects register, data port accesses
// R11 - shared i/o base from config 44h
// R12 - index 00..3f socket a, 40..7f b
// R13 - memory alias at window offset 800h
// R14 - each function alias reaches own socket
// R15 - alias spans 800h..844h in 4K window
// R16 - write one clears status, zero keeps
// R17 - event low while routed and status and enable pair
`default_nettype none
module general_event_legacy_regs #(
	parameter int NUM_SOCKETS = 2 // sockets served
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// request ports
	input wire general_event_legacy_pkg::cfg_req_t i_cfg,
	input wire general_event_legacy_pkg::io_req_t i_io,
	input wire general_event_legacy_pkg::mem_req_t i_mem,
	// socket levels
	input wire logic [1:0] i_zoomed_video_on,
	input wire logic [1:0] i_high_prog_voltage_req,
	// answers
	output logic [31:0] o_cfg_rdata,
	output logic o_cfg_ack,
	output logic [7:0] o_io_rdata,
	output logic o_io_ack,
	output logic [7:0] o_mem_rdata,
	output logic o_mem_ack,
	// event pin, active low
	output logic o_general_event_out_n
);
	import general_event_legacy_pkg::*;

	// the index/data scheme and the alias are built for exactly two sockets
	if (NUM_SOCKETS != 2) begin : g_bad_sockets
		$error("NUM_SOCKETS must be 2");
	end

	// merge write data into an old word under byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// configuration state
	logic [31:WIN_LSB] sock_base_q [2], sock_base_d [2]; // window base per function
	logic [15:0] legacy_base_q, legacy_base_d; // shared i/o base
	logic [2:0] route_q, route_d; // terminal five routing code
	logic [2:0] sts_q, sts_d; // video1, video0, voltage status
	logic [2:0] en_q, en_d; // video1, video0, voltage enable
	// change detection
	logic [1:0] vid_prev_q, vid_prev_d; // last video enable levels
	logic [1:0] hpv_prev_q, hpv_prev_d; // last 12 v request levels
	logic primed_q, primed_d; // prev registers hold real samples
	// legacy access
	logic [7:0] index_q, index_d; // index port value
	logic [7:0] legacy_q [128], legacy_d [128]; // legacy registers, both sockets
	// answer registers
	logic [31:0] cfg_rdata_d;
	logic cfg_ack_d;
	logic [7:0] io_rdata_d, mem_rdata_d;
	logic io_ack_d, mem_ack_d, event_out_n_d;

	// decode helpers
	logic cfg_wr_event; // config write hits event register
	logic [2:0] sts_set; // change events this cycle
	logic [2:0] sts_clr; // write-one clears this cycle
	logic io_hit; // i/o address on index or data port
	logic mem_hit; // memory address inside alias range
	logic [11:0] mem_off; // offset within 4K window
	logic [6:0] mem_idx; // legacy register picked by alias
	logic [15:0] event_rd; // event register read value
	logic [31:0] cfg_merged; // config write word after byte lane merge

	// config and event next state
	always_comb begin
		sock_base_d = sock_base_q;
		legacy_base_d = legacy_base_q;
		route_d = route_q;
		en_d = en_q;
		cfg_rdata_d = '0;
		cfg_ack_d = i_cfg.valid;
		cfg_merged = '0;
		vid_prev_d = i_zoomed_video_on;
		hpv_prev_d = i_high_prog_voltage_req;
		primed_d = 1'b1;
		// change detectors, quiet until the first sample is held
		sts_set[2] = primed_q & (i_zoomed_video_on[1] ^ vid_prev_q[1]); // R3
		sts_set[1] = primed_q & (i_zoomed_video_on[0] ^ vid_prev_q[0]); // R4
		sts_set[0] = primed_q & (|(i_high_prog_voltage_req ^ hpv_prev_q)); // R5
		cfg_wr_event = i_cfg.valid & i_cfg.write & (i_cfg.offset == CFG_EVENT);
		// ones written to status clear it, zeros leave it
		sts_clr = (cfg_wr_event & i_cfg.be[STS_BE]) ? i_cfg.wdata[STS_LSB +: 3] : 3'h0; // R16
		// a new event beats a clear in the same cycle
		sts_d = (sts_q & ~sts_clr) | sts_set; // R16
		// reserved bits are constant zero
		event_rd = {5'h00, sts_q, 5'h00, en_q}; // R2 R6
		if (i_cfg.valid && i_cfg.write) begin
			unique case (i_cfg.offset)
				CFG_SOCK_BASE: begin
					// each function keeps its own window; merge first, then keep the base bits
					cfg_merged = be_merge({sock_base_q[i_cfg.func], 12'h000}, i_cfg.wdata,
						i_cfg.be);
					sock_base_d[i_cfg.func] = cfg_merged[31:WIN_LSB]; // R14
				end
				CFG_LEGACY_BASE: begin
					// one base for both sockets
					cfg_merged = be_merge({16'h0000, legacy_base_q}, i_cfg.wdata, i_cfg.be);
					legacy_base_d = cfg_merged[15:0]; // R11
				end
				CFG_ROUTE: begin
					if (i_cfg.be[ROUTE_BE]) begin
						route_d = i_cfg.wdata[ROUTE_LSB +: 3];
					end
				end
				CFG_EVENT: begin
					if (i_cfg.be[EN_BE]) begin
						en_d = i_cfg.wdata[2:0];
					end
				end
				default: begin
					// other offsets belong elsewhere
				end
			endcase
		end
		// read mux
		unique case (i_cfg.offset)
			CFG_SOCK_BASE: cfg_rdata_d = {sock_base_q[i_cfg.func], 12'h000};
			CFG_LEGACY_BASE: cfg_rdata_d = {16'h0000, legacy_base_q};
			CFG_ROUTE: cfg_rdata_d = {9'h000, route_q, 20'h0_0000};
			CFG_EVENT: cfg_rdata_d = {16'h0000, event_rd};
			default: cfg_rdata_d = '0;
		endcase
		// event pin only follows the register once routed to terminal five
		event_out_n_d = ~((route_q == ROUTE_EVENT_CODE) & (|(sts_q & en_q))); // R1 R7 R8 R9 R17
	end

	// legacy register access next state
	always_comb begin
		legacy_d = legacy_q;
		index_d = index_q;
		io_rdata_d = 8'h00;
		mem_rdata_d = 8'h00;
		// index at base, data at base plus one
		io_hit = i_io.valid & (i_io.addr[15:1] == legacy_base_q[15:1]); // R11
		io_ack_d = io_hit;
		if (io_hit && !i_io.addr[0]) begin
			// index port
			io_rdata_d = index_q;
			if (i_io.write) begin
				index_d = i_io.wdata; // R10
			end
		end else if (io_hit && !index_q[IDX_OOR_BIT]) begin
			// data port; bit 6 of the index picks socket b
			io_rdata_d = legacy_q[index_q[6:0]]; // R10 R12
			if (i_io.write) begin
				legacy_d[index_q[6:0]] = i_io.wdata; // R12
			end
		end
		// memory alias inside the function's own window
		mem_off = i_mem.addr[WIN_LSB-1:0];
		mem_hit = i_mem.valid && (i_mem.addr[31:WIN_LSB] == sock_base_q[i_mem.func])
			&& (mem_off >= ALIAS_LO) && (mem_off <= ALIAS_HI); // R13 R15
		mem_idx = {i_mem.func, mem_off[5:0]}; // R14
		mem_ack_d = mem_hit;
		if (mem_hit && (mem_off < ALIAS_REG_END)) begin
			mem_rdata_d = legacy_q[mem_idx];
			if (i_mem.write) begin
				legacy_d[mem_idx] = i_mem.wdata; // R13
			end
		end
	end

	// register all state and answers
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			sock_base_q <= '{default: '0};
			legacy_base_q <= 16'h0000;
			route_q <= 3'h0;
			sts_q <= EVENT_RESET[STS_LSB +: 3];
			en_q <= EVENT_RESET[2:0];
			vid_prev_q <= 2'h0;
			hpv_prev_q <= 2'h0;
			primed_q <= 1'b0;
			index_q <= 8'h00;
			legacy_q <= '{default: '0};
			o_cfg_rdata <= 32'h0000_0000;
			o_cfg_ack <= 1'b0;
			o_io_rdata <= 8'h00;
			o_io_ack <= 1'b0;
			o_mem_rdata <= 8'h00;
			o_mem_ack <= 1'b0;
			o_general_event_out_n <= 1'b1;
		end else begin
			sock_base_q <= sock_base_d;
			legacy_base_q <= legacy_base_d;
			route_q <= route_d;
			sts_q <= sts_d;
			en_q <= en_d;
			vid_prev_q <= vid_prev_d;
			hpv_prev_q <= hpv_prev_d;
			primed_q <= primed_d;
			index_q <= index_d;
			legacy_q <= legacy_d;
			o_cfg_rdata <= cfg_rdata_d;
			o_cfg_ack <= cfg_ack_d;
			o_io_rdata <= io_rdata_d;
			o_io_ack <= io_ack_d;
			o_mem_rdata <= mem_rdata_d;
			o_mem_ack <= mem_ack_d;
			o_general_event_out_n <= event_out_n_d;
		end
	end

	// checks
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	a_route_gates_pin: assert property ((route_q != ROUTE_EVENT_CODE) |=> // R1
		o_general_event_out_n) else $error("event pin low without routing");
	a_rsvd_high_zero: assert property ((i_cfg.valid && i_cfg.offset == CFG_EVENT) |=> // R2
		(o_cfg_rdata[15:11] == 5'h00)) else $error("event bits 15..11 not zero");
	a_vid1_sets: assert property ((primed_q && $changed(i_zoomed_video_on[1])) |=> // R3
		sts_q[2]) else $error("socket 1 video change not flagged");
	a_vid0_sets: assert property ((primed_q && $changed(i_zoomed_video_on[0])) |=> // R4
		sts_q[1]) else $error("socket 0 video change not flagged");
	a_volt_sets: assert property ((primed_q && i_high_prog_voltage_req != hpv_prev_q) |=> // R5
		sts_q[0]) else $error("12 v request change not flagged");
	a_rsvd_low_zero: assert property ((i_cfg.valid && i_cfg.offset == CFG_EVENT) |=> // R6
		(o_cfg_rdata[7:3] == 5'h00)) else $error("event bits 7..3 not zero");
	a_vid1_drives: assert property ((route_q == ROUTE_EVENT_CODE && en_q[2] && sts_q[2]) // R7
		|=> !o_general_event_out_n) else $error("enabled socket 1 event not driven");
	a_vid0_drives: assert property ((route_q == ROUTE_EVENT_CODE && en_q[1] && sts_q[1]) // R8
		|=> !o_general_event_out_n) else $error("enabled socket 0 event not driven");
	a_volt_drives: assert property ((route_q == ROUTE_EVENT_CODE && en_q[0] && sts_q[0]) // R9
		|=> !o_general_event_out_n) else $error("enabled voltage event not driven");
	a_index_loads: assert property ((io_hit && !i_io.addr[0] && i_io.write) |=> // R10
		(index_q == $past(i_io.wdata))) else $error("index port not loaded");
	a_io_base_match: assert property ((i_io.valid && i_io.addr[15:1] != legacy_base_q[15:1]) // R11
		|=> !o_io_ack) else $error("i/o answered off base");
	a_mem_alias_ack: assert property ((i_mem.valid && i_mem.addr[31:WIN_LSB] == // R13
		sock_base_q[i_mem.func] && i_mem.addr[11:0] == ALIAS_HI) |=> o_mem_ack)
		else $error("alias top byte not answered");
	a_mem_own_win: assert property ((i_mem.valid && i_mem.addr[31:WIN_LSB] != // R14
		sock_base_q[i_mem.func]) |=> !o_mem_ack) else $error("alias answered outside window");
	a_clear_one: assert property ((cfg_wr_event && i_cfg.be[STS_BE] && i_cfg.wdata[10] && // R16
		!sts_set[2]) |=> !sts_q[2]) else $error("write one did not clear status");
	a_idle_release: assert property ((~|(sts_q & en_q)) |=> o_general_event_out_n) // R17
		else $error("event pin low with no pending pair");
endmodule
`default_nettype wire

// >>> test/host_bus_model.sv
/*
 * host model: issues one config, i/o or memory request per task call.
 * assumes the bench calls its tasks by instance path and samples answers after return.
 */
`default_nettype none
module host_bus_model (
	// clock
	input wire logic i_sys_clk,
	// requests toward the block
	output var general_event_legacy_pkg::cfg_req_t o_cfg,
	output var general_event_legacy_pkg::io_req_t o_io,
	output var general_event_legacy_pkg::mem_req_t o_mem
);
	timeunit 1ns;
	timeprecision 1ns;
	import general_event_legacy_pkg::*;
	// idle until the first call
	initial begin
		o_cfg = '0;
		o_io = '0;
		o_mem = '0;
	end
	// config access; released lines show inverted values so stale data never matches
	task automatic cfg(input logic w, f, input logic [7:0] o, input logic [3:0] b,
		input logic [31:0] d);
		@(posedge i_sys_clk);
		o_cfg <= '{1'b1, w, f, o, b, d};
		@(posedge i_sys_clk);
		o_cfg <= '{1'b0, w, f, ~o, b, ~d};
		@(negedge i_sys_clk);
	endtask
	// byte i/o access; index at base, data at base plus one
	task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		o_io <= '{1'b1, w, a, d};
		@(posedge i_sys_clk);
		o_io <= '{1'b0, w, ~a, ~d};
		@(negedge i_sys_clk);
	endtask
	// byte memory access into one function's window
	task automatic mem(input logic w, f, input logic [31:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		o_mem <= '{1'b1, w, f, a, d};
		@(posedge i_sys_clk);
		o_mem <= '{1'b0, w, f, ~a, ~d};
		@(negedge i_sys_clk);
	endtask
endmodule
`default_nettype wire

// >>> test/general_event_legacy_regs_test.sv
/*
 * self-checking bench for the general event register and legacy access paths.
 * assumes host_bus_model drives the request ports and the design package is compiled.
 */
`default_nettype none
module general_event_legacy_regs_test import general_event_legacy_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0; // system clock
	logic rst_n = 1'b0; // reset, active low
	logic [1:0] zv = 2'b00; // video enable levels
	logic [1:0] vpp = 2'b00; // 12 v request levels
	cfg_req_t cfg; // config request
	io_req_t io; // i/o request
	mem_req_t mem; // memory request
	logic [31:0] cfg_rd; // answers
	logic cfg_ack;
	logic [7:0] io_rd;
	logic io_ack;
	logic [7:0] mem_rd;
	logic mem_ack;
	logic ev_n; // event pin
	int bad_count = 0;
	int check_count = 0;
	logic [15:0] seed = 16'he493; // random source
	logic [19:0] wb [2] = '{20'h8_0001, 20'h8_0002}; // window bases per function
	logic [15:0] base; // i/o base
	logic [7:0] idx; // legacy index
	logic [7:0] d; // legacy data
	logic [2:0] en; // enables
	logic [31:0] a; // alias address
	int src; // event source
	initial forever #20 clk = ~clk;
	general_event_legacy_regs dut (.i_sys_clk(clk), .i_resetn(rst_n), .i_cfg(cfg), .i_io(io),
		.i_mem(mem), .i_zoomed_video_on(zv), .i_high_prog_voltage_req(vpp),
		.o_cfg_rdata(cfg_rd), .o_cfg_ack(cfg_ack), .o_io_rdata(io_rd), .o_io_ack(io_ack),
		.o_mem_rdata(mem_rd), .o_mem_ack(mem_ack), .o_general_event_out_n(ev_n));
	host_bus_model host (.i_sys_clk(clk), .o_cfg(cfg), .o_io(io), .o_mem(mem));
	// next random value
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// counts, verdict, end of run
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// flip one event source: 0 voltage request, 1 socket 0 video, 2 socket 1 video
	task automatic toggle(input int s);
		@(posedge clk);
		if (s == 0) vpp[seed[8]] <= ~vpp[seed[8]];
		else zv[s - 1] <= ~zv[s - 1];
		repeat (3) @(posedge clk);
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		host.cfg(1'b0, 1'b0, CFG_EVENT, 4'hf, 32'h0);
		check(cfg_rd, 32'h0000_0001);
		check(32'(cfg_ack), 32'h1);
		// event before routing: status sets, pin stays idle
		toggle(0);
		host.cfg(1'b0, 1'b0, CFG_EVENT, 4'hf, 32'h0);
		check(cfg_rd, 32'h0000_0101);
		check(32'(ev_n), 32'h1);
		host.cfg(1'b1, 1'b0, CFG_ROUTE, 4'h4, 32'h0050_0000);
		@(negedge clk);
		check(32'(ev_n), 32'h0);
		host.cfg(1'b0, 1'b0, CFG_ROUTE, 4'hf, 32'h0);
		check(cfg_rd, 32'h0050_0000);
		// clear the voltage status left by the routing test so the loop starts clean
		host.cfg(1'b1, 1'b0, CFG_EVENT, 4'h2, 32'h0000_0100);
		@(negedge clk);
		check(32'(ev_n), 32'h1);
		// random enables against each source; zero write keeps, one write clears
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			src = int'(seed % 16'h3);
			en = seed[6:4];
			host.cfg(1'b1, 1'b0, CFG_EVENT, 4'h1, {29'h0, en});
			toggle(src);
			host.cfg(1'b0, 1'b0, CFG_EVENT, 4'hf, 32'h0);
			check(cfg_rd, {21'h0, 3'b001 << src, 5'h0, en});
			check(32'(ev_n), 32'(!en[src]));
			host.cfg(1'b1, 1'b0, CFG_EVENT, 4'h2, 32'h0);
			@(negedge clk);
			check(32'(ev_n), 32'(!en[src]));
			host.cfg(1'b1, 1'b0, CFG_EVENT, 4'h2, 32'h0000_0700);
			@(negedge clk);
			check(32'(ev_n), 32'h1);
		end
		// legacy access through the shared i/o pair and both memory windows
		seed = lfsr(seed);
		base = {seed[15:1], 1'b0};
		host.cfg(1'b1, 1'b0, CFG_LEGACY_BASE, 4'h3, {16'h0, base});
		host.cfg(1'b1, 1'b0, CFG_SOCK_BASE, 4'hf, {wb[0], 12'h0});
		host.cfg(1'b1, 1'b1, CFG_SOCK_BASE, 4'hf, {wb[1], 12'h0});
		for (int i = 0; i < 10; i++) begin
			seed = lfsr(seed);
			idx = {1'b0, seed[6:0]};
			d = seed[15:8];
			a = {wb[idx[6]], 6'h20, idx[5:0]};
			host.io(1'b1, base, idx);
			host.io(1'b1, base | 16'h1, d);
			host.io(1'b0, base, 8'h0);
			check(32'(io_rd), 32'(idx));
			host.mem(1'b0, idx[6], a, 8'h0);
			check(32'({mem_ack, mem_rd}), 32'({1'b1, d}));
			host.mem(1'b0, !idx[6], a, 8'h0);
			check(32'(mem_ack), 32'h0);
			host.mem(1'b1, idx[6], a, ~d);
			host.io(1'b0, base | 16'h1, 8'h0);
			check(32'({io_ack, io_rd}), 32'({1'b1, ~d}));
		end
		// index above the register set, off-base port, window edges
		host.io(1'b1, base, 8'h85);
		host.io(1'b0, base | 16'h1, 8'h0);
		check(32'(io_rd), 32'h0);
		host.io(1'b0, base + 16'h2, 8'h0);
		check(32'(io_ack), 32'h0);
		host.mem(1'b0, 1'b0, {wb[0], 12'h844}, 8'h0);
		check(32'({mem_ack, mem_rd}), 32'h100);
		host.mem(1'b0, 1'b0, {wb[0], 12'h845}, 8'h0);
		check(32'(mem_ack), 32'h0);
		host.mem(1'b0, 1'b1, {wb[1], 12'h7ff}, 8'h0);
		check(32'(mem_ack), 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
